/* verilog/cod_map.svh */
`ifndef COD_MAP_SVH
`define COD_MAP_SVH

// object indices of the dictionary
`define COD_IDX_TX_LIST 16'h1c13
`define COD_IDX_CFG_LO 16'h4000
`define COD_IDX_CFG_HI 16'h4001
`define COD_IDX_INV_LO 16'h4012
`define COD_IDX_INV_HI 16'h4013
`define COD_IDX_DIAG_LO 16'h40b4
`define COD_IDX_DIAG_HI 16'h40b5
`define COD_IDX_UPD 16'h40c4

// bus address layout: byte address = {index, subindex, 2'b00}
`define COD_ADR_IDX_LSB 10
`define COD_ADR_SUB_LSB 2

// transmit assignment values
`define COD_STATUS_PDO 16'h1aff
`define COD_TXPDO_BASE 16'h1a00
`define COD_ALIGN_PDO 16'h1b01

// object lengths and update-time subindices
`define COD_TABLE_LEN 16'h0080
`define COD_TABLE_REGS 9'h080
`define COD_UPD_LEN 16'h0005
`define COD_UPD_SUB_MIN 8'h01
`define COD_UPD_SUB_MAX 8'h02
`define COD_UPD_SUB_CUR 8'h03

// inventory word field positions
`define COD_INV_KIND_BIT 15
`define COD_INV_SIZE_LSB 8
`define COD_INV_SIZE_MSB 14
`define COD_INV_PANEL_BIT 7
`define COD_INV_OUT_BIT 1
`define COD_INV_IN_BIT 0

// reset values of the update-time statistics
`define COD_UPD_MIN_RST 16'hffff
`define COD_UPD_MAX_RST 16'h0000
`define COD_UPD_CUR_RST 16'h0000

// timing: clock period and one microsecond, both in ns
`define COD_CLK_PERIOD_NS 10
`define COD_US_NS 1000
`define COD_CYC_PER_US (`COD_US_NS / `COD_CLK_PERIOD_NS)

`endif

/* verilog/cod_pkg.sv */
package cod_pkg;

  // one attached terminal as reported by the local bus scan
  typedef struct packed {
    logic digital;
    logic [14:0] type_num;
    logic [5:0] size_bits;
    logic panel_ext;
    logic is_input;
    logic is_output;
  } cod_inv_entry_t;

  // one write into the transmit assignment list
  typedef struct packed {
    logic en;
    logic [7:0] sub;
    logic [15:0] pdo;
  } cod_list_wr_t;

  typedef enum logic [1:0] {
    BLD_IDLE,
    BLD_ANALOG,
    BLD_DIGITAL,
    BLD_TAIL
  } cod_bld_state_t;

endpackage

/* verilog/cod_txpdo_builder.sv */
`timescale 1ns/10ps
`include "cod_map.svh"

module cod_txpdo_builder
  import cod_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic start_i, // rebuild request pulse
  input wire logic [7:0] term_count_i, // attached terminals
  output logic [7:0] inv_idx_o, // inventory read index
  input wire logic [15:0] inv_word_i, // inventory word at inv_idx_o
  output cod_list_wr_t list_wr_o, // list write port
  output logic done_o, // pulse, list complete
  output logic [7:0] count_o, // entries, valid with done_o
  output logic busy_o // walk in progress
);

  cod_bld_state_t state_ff, nxt_state;
  logic [7:0] scan_ff, nxt_scan;
  logic [7:0] ptr_ff, nxt_ptr;
  logic last;
  logic room;

  assign last = (scan_ff >= term_count_i);
  // one slot always stays free for the alignment dummy
  assign room = (ptr_ff < 8'hff);
  assign inv_idx_o = scan_ff;
  assign busy_o = (state_ff != BLD_IDLE);
  assign count_o = ptr_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_scan = scan_ff;
    nxt_ptr = ptr_ff;
    list_wr_o = '0;
    done_o = 1'b0;
    case (state_ff)
      BLD_IDLE: begin
        if (start_i) begin
          list_wr_o = '{en: 1'b1, sub: 8'h01, pdo: `COD_STATUS_PDO};
          nxt_scan = 8'h01;
          nxt_ptr = 8'h02;
          nxt_state = (term_count_i == 8'h00) ? BLD_TAIL : BLD_ANALOG;
        end
      end
      BLD_ANALOG: begin
        if (!inv_word_i[`COD_INV_KIND_BIT] && room) begin
          list_wr_o = '{en: 1'b1, sub: ptr_ff, pdo: `COD_TXPDO_BASE | {8'h00, scan_ff}};
          nxt_ptr = ptr_ff + 8'h01;
        end
        nxt_scan = last ? 8'h01 : scan_ff + 8'h01;
        if (last) begin
          nxt_state = BLD_DIGITAL;
        end
      end
      BLD_DIGITAL: begin
        if (inv_word_i[`COD_INV_KIND_BIT] && room) begin
          list_wr_o = '{en: 1'b1, sub: ptr_ff, pdo: `COD_TXPDO_BASE | {8'h00, scan_ff}};
          nxt_ptr = ptr_ff + 8'h01;
        end
        nxt_scan = scan_ff + 8'h01;
        if (last) begin
          nxt_state = BLD_TAIL;
        end
      end
      BLD_TAIL: begin
        list_wr_o = '{en: 1'b1, sub: ptr_ff, pdo: `COD_ALIGN_PDO};
        done_o = 1'b1;
        nxt_state = BLD_IDLE;
      end
      default: begin
        nxt_state = BLD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= BLD_IDLE;
      scan_ff <= 8'h00;
      ptr_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      scan_ff <= nxt_scan;
      ptr_ff <= nxt_ptr;
    end
  end

endmodule

/* verilog/cod_object_dictionary.sv */
// Behaviour
// - after a rebuild, list subindex 1 holds the status PDO 0x1aff.
// - after that, the list holds analog terminal PDOs in order, then digital ones.
// - the last populated list entry is the digital alignment dummy 0x1b01.
// - configuration is two read-write tables of 128 words covering registers 0 to 255.
// - inventory is read-only, register 0 is the coupler, register n the n-th terminal, 128 up in the high table.
// - coupler and intelligent terminals report their type number as plain binary.
// - inventory bit 15 is 0 for intelligent and 1 for simple digital terminals.
// - a digital word carries its size in bits, 0 to 63, just below bit 15.
// - a digital word sets bit 7 for a control-panel shift-register extension.
// - a digital word sets bit 0 for input, bit 1 for output, both clear for mixed.
// - two read-only diagnostic tables of 128 reserved words cover registers 0 to 255.
// - update-time subindex 1 gives the minimum and 2 the maximum, in microseconds.
// - update-time subindex 3 gives the latest measured update time in microseconds.
//
// Chosen here: register access over Wishbone.
`timescale 1ns/10ps
`include "cod_map.svh"

module cod_object_dictionary
  import cod_pkg::*;
#(
  parameter logic [15:0] COUPLER_TYPE = 16'h0123, // arbitrary value
  parameter int MAX_TERMS = 255
) (
  input wire logic clk_i, // 100 MHz
  input wire logic rst_i, // sync reset, high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [31:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic inv_wr_i, // inventory entry strobe
  input wire logic [7:0] inv_idx_i, // terminal number 1..255
  input wire cod_inv_entry_t inv_ent_i, // terminal description
  input wire logic [7:0] term_count_i, // attached terminals
  input wire logic rebuild_i, // rebuild assignment list
  input wire logic local_start_i, // local bus cycle start
  input wire logic local_end_i, // local bus cycle end
  output logic [7:0] txlist_len_o, // assignment entries
  output logic build_busy_o // list rebuild running
);

  generate
    if (MAX_TERMS < 1 || MAX_TERMS > 255) begin : g_bad_terms
      $error("MAX_TERMS must be 1 to 255");
    end
  endgenerate

  localparam int CYC_PER_US = `COD_CYC_PER_US;
  localparam logic [6:0] PRESCALE_LAST = 7'(CYC_PER_US - 1);

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] sel);
    merge16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

  // table register number from half and subindex 1..128
  function automatic logic [7:0] slot(input logic hi, input logic [7:0] sub);
    slot = {hi, 7'(sub - 8'h01)};
  endfunction

  function automatic logic [15:0] enc_inv(input cod_inv_entry_t e);
    logic [15:0] w;
    w = {1'b0, e.type_num};
    if (e.digital) begin
      w = 16'h0000;
      w[`COD_INV_KIND_BIT] = 1'b1;
      w[`COD_INV_SIZE_MSB:`COD_INV_SIZE_LSB] = {1'b0, e.size_bits};
      w[`COD_INV_PANEL_BIT] = e.panel_ext;
      w[`COD_INV_OUT_BIT] = e.is_output;
      w[`COD_INV_IN_BIT] = e.is_input;
    end
    enc_inv = w;
  endfunction

  logic [15:0] cfg_mem [0:255];
  logic [15:0] inv_mem [0:255];
  logic [15:0] txlist_mem [0:255];

  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic boot_ff, nxt_boot;
  logic [7:0] txcnt_ff, nxt_txcnt;
  logic [15:0] min_ff, nxt_min;
  logic [15:0] max_ff, nxt_max;
  logic [15:0] cur_ff, nxt_cur;
  logic run_ff, nxt_run;
  logic [6:0] ps_ff, nxt_ps;
  logic [15:0] us_ff, nxt_us;

  logic req;
  logic wr;
  logic [15:0] idx;
  logic [7:0] sub;
  logic in_tbl;
  logic hi_half;
  logic [7:0] rslot;
  logic [15:0] rd_word;
  logic [15:0] inv_len;
  logic [8:0] inv_total;
  logic cfg_we;
  logic [15:0] cfg_wd;
  cod_list_wr_t sw_list_wr;
  cod_list_wr_t bld_list_wr;
  cod_list_wr_t list_wr;
  logic [7:0] bld_inv_idx;
  logic [15:0] bld_inv_word;
  logic bld_done;
  logic [7:0] bld_count;
  logic bld_busy;
  logic meas_evt;

  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr = req & wb_we_i;
  assign idx = wb_adr_i[`COD_ADR_IDX_LSB +: 16];
  assign sub = wb_adr_i[`COD_ADR_SUB_LSB +: 8];
  assign in_tbl = (sub != 8'h00) && ({1'b0, sub} <= `COD_TABLE_REGS);
  assign hi_half = (idx == `COD_IDX_CFG_HI) || (idx == `COD_IDX_INV_HI);
  assign rslot = slot(hi_half, sub);
  assign inv_total = {1'b0, term_count_i} + 9'h001;
  assign bld_inv_word = inv_mem[bld_inv_idx];
  assign meas_evt = local_end_i & run_ff;

  // subindex 0 of each inventory half counts the words it holds
  always_comb begin
    if (idx == `COD_IDX_INV_LO) begin
      inv_len = (inv_total > `COD_TABLE_REGS) ? `COD_TABLE_LEN : {7'h00, inv_total};
    end else begin
      inv_len = (inv_total > `COD_TABLE_REGS) ? {7'h00, 9'(inv_total - `COD_TABLE_REGS)} : 16'h0000;
    end
  end

  always_comb begin
    rd_word = 16'h0000;
    case (idx)
      `COD_IDX_TX_LIST: begin
        rd_word = (sub == 8'h00) ? {8'h00, txcnt_ff} : txlist_mem[sub];
      end
      `COD_IDX_CFG_LO, `COD_IDX_CFG_HI: begin
        if (sub == 8'h00) begin
          rd_word = `COD_TABLE_LEN;
        end else if (in_tbl) begin
          rd_word = cfg_mem[rslot];
        end
      end
      `COD_IDX_INV_LO, `COD_IDX_INV_HI: begin
        if (sub == 8'h00) begin
          rd_word = inv_len;
        end else if (in_tbl) begin
          rd_word = (rslot == 8'h00) ? COUPLER_TYPE : inv_mem[rslot];
        end
      end
      `COD_IDX_DIAG_LO, `COD_IDX_DIAG_HI: begin
        rd_word = (sub == 8'h00) ? `COD_TABLE_LEN : 16'h0000;
      end
      `COD_IDX_UPD: begin
        case (sub)
          8'h00: rd_word = `COD_UPD_LEN;
          `COD_UPD_SUB_MIN: rd_word = min_ff;
          `COD_UPD_SUB_MAX: rd_word = max_ff;
          `COD_UPD_SUB_CUR: rd_word = cur_ff;
          default: rd_word = 16'h0000;
        endcase
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  // bus handshake: one wait state, unmapped reads return zero
  always_comb begin
    nxt_ack = req;
    nxt_dat = dat_ff;
    if (req && !wb_we_i) begin
      nxt_dat = {16'h0000, rd_word};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // configuration tables
  always_comb begin
    cfg_we = wr && in_tbl && (idx == `COD_IDX_CFG_LO || idx == `COD_IDX_CFG_HI);
    cfg_wd = merge16(cfg_mem[rslot], wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge clk_i) begin
    if (cfg_we) begin
      cfg_mem[rslot] <= cfg_wd;
    end
  end

  // inventory is filled by the scan logic only; bus writes never reach it
  always_ff @(posedge clk_i) begin
    if (inv_wr_i && inv_idx_i != 8'h00) begin
      inv_mem[inv_idx_i] <= enc_inv(inv_ent_i);
    end
  end

  // assignment list: the builder owns the port while busy
  always_comb begin
    sw_list_wr.en = wr && (idx == `COD_IDX_TX_LIST) && (sub != 8'h00);
    sw_list_wr.sub = sub;
    sw_list_wr.pdo = merge16(txlist_mem[sub], wb_dat_i, wb_sel_i);
    list_wr = bld_busy || bld_list_wr.en ? bld_list_wr : sw_list_wr;
  end

  always_ff @(posedge clk_i) begin
    if (list_wr.en) begin
      txlist_mem[list_wr.sub] <= list_wr.pdo;
    end
  end

  always_comb begin
    nxt_boot = 1'b0;
    nxt_txcnt = txcnt_ff;
    if (bld_done) begin
      nxt_txcnt = bld_count;
    end else if (!bld_busy && wr && idx == `COD_IDX_TX_LIST && sub == 8'h00 && wb_sel_i[0]) begin
      nxt_txcnt = wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_ff <= 1'b1;
      txcnt_ff <= 8'h00;
    end else begin
      boot_ff <= nxt_boot;
      txcnt_ff <= nxt_txcnt;
    end
  end

  assign txlist_len_o = txcnt_ff;

  cod_txpdo_builder i_cod_txpdo_builder (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(boot_ff | rebuild_i),
    .term_count_i(term_count_i),
    .inv_idx_o(bld_inv_idx),
    .inv_word_i(bld_inv_word),
    .list_wr_o(bld_list_wr),
    .done_o(bld_done),
    .count_o(bld_count),
    .busy_o(bld_busy)
  );

  logic busy_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= bld_busy;
    end
  end
  assign build_busy_o = busy_ff;

  // update-time measurement; a measurement beats a software write in the same cycle
  always_comb begin
    nxt_run = run_ff;
    nxt_ps = ps_ff;
    nxt_us = us_ff;
    nxt_min = min_ff;
    nxt_max = max_ff;
    nxt_cur = cur_ff;
    if (wr && idx == `COD_IDX_UPD) begin
      case (sub)
        `COD_UPD_SUB_MIN: nxt_min = merge16(min_ff, wb_dat_i, wb_sel_i);
        `COD_UPD_SUB_MAX: nxt_max = merge16(max_ff, wb_dat_i, wb_sel_i);
        `COD_UPD_SUB_CUR: nxt_cur = merge16(cur_ff, wb_dat_i, wb_sel_i);
        default: nxt_cur = cur_ff;
      endcase
    end
    if (run_ff) begin
      nxt_ps = (ps_ff == PRESCALE_LAST) ? 7'h00 : ps_ff + 7'h01;
      // saturate rather than wrap on a stalled bus
      if (ps_ff == PRESCALE_LAST && us_ff != 16'hffff) begin
        nxt_us = us_ff + 16'h0001;
      end
    end
    if (meas_evt) begin
      nxt_run = 1'b0;
      nxt_cur = us_ff;
      if (us_ff < min_ff) begin
        nxt_min = us_ff;
      end
      if (us_ff > max_ff) begin
        nxt_max = us_ff;
      end
    end
    if (local_start_i) begin
      nxt_run = 1'b1;
      nxt_ps = 7'h00;
      nxt_us = 16'h0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_ff <= 1'b0;
      ps_ff <= 7'h00;
      us_ff <= 16'h0000;
      min_ff <= `COD_UPD_MIN_RST;
      max_ff <= `COD_UPD_MAX_RST;
      cur_ff <= `COD_UPD_CUR_RST;
    end else begin
      run_ff <= nxt_run;
      ps_ff <= nxt_ps;
      us_ff <= nxt_us;
      min_ff <= nxt_min;
      max_ff <= nxt_max;
      cur_ff <= nxt_cur;
    end
  end

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");

  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged next cycle");

  property p_status_first;
    @(posedge clk_i) disable iff (rst_i) bld_done |=> txlist_mem[1] == `COD_STATUS_PDO;
  endproperty
  a_status_first: assert property (p_status_first) else $error("first list entry is not the status PDO");

  property p_align_last;
    @(posedge clk_i) disable iff (rst_i) bld_done |=> txlist_mem[txcnt_ff] == `COD_ALIGN_PDO && !bld_busy;
  endproperty
  a_align_last: assert property (p_align_last) else $error("last list entry is not the alignment dummy");

  property p_build_len;
    @(posedge clk_i) disable iff (rst_i) $rose(bld_busy) |-> ##[0:600] bld_done;
  endproperty
  a_build_len: assert property (p_build_len) else $error("list rebuild did not finish in time");

  property p_inv_digital;
    @(posedge clk_i) disable iff (rst_i) (inv_wr_i && inv_idx_i != 8'h00 && inv_ent_i.digital) |=>
      inv_mem[$past(inv_idx_i)][15] && inv_mem[$past(inv_idx_i)][13:8] == $past(inv_ent_i.size_bits);
  endproperty
  a_inv_digital: assert property (p_inv_digital) else $error("digital inventory word badly coded");

  property p_inv_dir;
    @(posedge clk_i) disable iff (rst_i) (inv_wr_i && inv_idx_i != 8'h00 && inv_ent_i.digital) |=>
      inv_mem[$past(inv_idx_i)][1:0] == {$past(inv_ent_i.is_output), $past(inv_ent_i.is_input)};
  endproperty
  a_inv_dir: assert property (p_inv_dir) else $error("digital direction bits wrong");

  property p_min_read;
    @(posedge clk_i) disable iff (rst_i) (req && !wb_we_i && idx == `COD_IDX_UPD && sub == `COD_UPD_SUB_MIN) |=>
      wb_ack_o && wb_dat_o[15:0] == $past(min_ff);
  endproperty
  a_min_read: assert property (p_min_read) else $error("minimum read returns wrong value");

  property p_cur_update;
    @(posedge clk_i) disable iff (rst_i) (meas_evt && !local_start_i) |=> cur_ff == $past(us_ff) && !run_ff;
  endproperty
  a_cur_update: assert property (p_cur_update) else $error("current time not refreshed");

  property p_minmax;
    @(posedge clk_i) disable iff (rst_i) meas_evt |=> min_ff <= cur_ff && max_ff >= cur_ff;
  endproperty
  a_minmax: assert property (p_minmax) else $error("min or max not widened");

  c_build: cover property (@(posedge clk_i) disable iff (rst_i) bld_done && bld_count > 8'h03);
  c_min_read: cover property (@(posedge clk_i) disable iff (rst_i) req && idx == `COD_IDX_UPD && sub == 8'h01);
  c_new_max: cover property (@(posedge clk_i) disable iff (rst_i) meas_evt && us_ff > max_ff);

endmodule

/* testbench/coupler_object_dictionary_tb_top.sv */
`timescale 1ns/10ps
`include "cod_map.svh"

module coupler_object_dictionary_tb_top;
  import cod_pkg::*;
  localparam logic [15:0] CPL_TYPE = 16'h0321; // arbitrary value
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, build_busy_o;
  logic inv_wr_i = 1'b0, rebuild_i = 1'b0, local_start_i = 1'b0, local_end_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h00000000, wb_dat_i = 32'h00000000, wb_dat_o;
  logic [3:0] wb_sel_i = 4'h0, wsel = 4'h3;
  logic [7:0] inv_idx_i = 8'h00, term_count_i = 8'h00, txlist_len_o;
  cod_inv_entry_t inv_ent_i = '0;
  int checks = 0, bad_count = 0, cycles = 0;
  logic [31:0] lfsr = 32'h000183bc;
  logic [15:0] rd, inv_exp[256];
  logic is_dig[256];
  logic [15:0] list_q[$];
  int dur[3] = '{250, 550, 150};
  int us_exp[3] = '{2, 5, 1};

  cod_object_dictionary #(.COUPLER_TYPE(CPL_TYPE), .MAX_TERMS(255)) i_cod_object_dictionary (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .inv_wr_i(inv_wr_i), .inv_idx_i(inv_idx_i), .inv_ent_i(inv_ent_i), .term_count_i(term_count_i),
    .rebuild_i(rebuild_i), .local_start_i(local_start_i), .local_end_i(local_end_i),
    .txlist_len_o(txlist_len_o), .build_busy_o(build_busy_o));

  initial forever #5 clk_i = ~clk_i;

  // hang guard, far above the roughly 1150 cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles >= 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // classic single cycle: hold everything until ack is sampled, then drop for a cycle
  task automatic wb(input logic we, input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] wd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {6'h00, idx, sub, 2'b00};
    wb_sel_i <= wsel;
    wb_dat_i <= {16'h0000, wd};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] e);
    wb(1'b0, idx, sub, 16'h0000);
    chk(nm, e, rd);
  endtask

  // bits: rebuild, cycle start, cycle end
  task automatic pulse(input logic [2:0] p);
    @(posedge clk_i);
    {rebuild_i, local_start_i, local_end_i} <= p;
    @(posedge clk_i);
    {rebuild_i, local_start_i, local_end_i} <= 3'b000;
  endtask

  task automatic wait_build();
    repeat (3) @(posedge clk_i);
    while (build_busy_o !== 1'b0) @(posedge clk_i);
  endtask

  task automatic inv_put(input logic [7:0] n, input logic dig);
    cod_inv_entry_t e;
    logic [31:0] r;
    r = rnd();
    e = '0;
    e.digital = dig;
    e.type_num = r[14:0];
    e.size_bits = r[21:16];
    e.panel_ext = r[22];
    e.is_input = r[23];
    e.is_output = r[24] & ~r[23];
    is_dig[n] = dig;
    if (dig) inv_exp[n] = {1'b1, 1'b0, e.size_bits, e.panel_ext, 5'h00, e.is_output, e.is_input};
    else inv_exp[n] = {1'b0, e.type_num};
    @(posedge clk_i);
    inv_wr_i <= 1'b1;
    inv_idx_i <= n;
    inv_ent_i <= e;
    @(posedge clk_i);
    inv_wr_i <= 1'b0;
  endtask

  initial begin
    logic [31:0] r;
    logic [15:0] mn, mx, cfg[4];
    int regs[4] = '{0, 127, 128, 255};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_build();

    for (int n = 1; n <= 4; n++) begin
      r = rnd();
      inv_put(n[7:0], r[0] ^ n[0]);
    end
    inv_put(8'd200, 1'b1);
    rd_chk("inventory coupler", 16'h4012, 8'h01, CPL_TYPE);
    for (int n = 1; n <= 4; n++) rd_chk("inventory word", 16'h4012, n[7:0] + 8'h01, inv_exp[n]);
    rd_chk("inventory high", 16'h4013, 8'd73, inv_exp[200]);
    wb(1'b1, 16'h4012, 8'h02, ~inv_exp[1]);
    rd_chk("inventory read only", 16'h4012, 8'h02, inv_exp[1]);
    $display("inventory test done");

    term_count_i <= 8'd4;
    pulse(3'b100);
    repeat (2) @(posedge clk_i);
    chk("build busy", 16'h0001, {15'h0000, build_busy_o});
    wait_build();
    list_q = {16'h1aff};
    for (int n = 1; n <= 4; n++) if (!is_dig[n]) list_q.push_back(16'h1a00 + n[15:0]);
    for (int n = 1; n <= 4; n++) if (is_dig[n]) list_q.push_back(16'h1a00 + n[15:0]);
    list_q.push_back(16'h1b01);
    chk("list length", 16'(list_q.size()), {8'h00, txlist_len_o});
    rd_chk("list length object", 16'h1c13, 8'h00, 16'(list_q.size()));
    for (int i = 0; i < list_q.size(); i++) rd_chk("list entry", 16'h1c13, i[7:0] + 8'h01, list_q[i]);
    $display("assignment list test done");

    for (int k = 0; k < 4; k++) begin
      r = rnd();
      cfg[k] = r[15:0];
      wb(1'b1, (regs[k] < 128) ? 16'h4000 : 16'h4001, 8'(regs[k] % 128 + 1), cfg[k]);
    end
    for (int k = 0; k < 4; k++) rd_chk("config reg", (regs[k] < 128) ? 16'h4000 : 16'h4001, 8'(regs[k] % 128 + 1), cfg[k]);
    rd_chk("config length low", 16'h4000, 8'h00, 16'h0080);
    rd_chk("config length high", 16'h4001, 8'h00, 16'h0080);
    // low byte lane only: the high byte must survive
    wsel = 4'h1;
    wb(1'b1, 16'h4000, 8'h01, 16'habcd);
    wsel = 4'h3;
    rd_chk("config byte lane", 16'h4000, 8'h01, {cfg[0][15:8], 8'hcd});
    $display("configuration test done");

    wb(1'b1, 16'h40b4, 8'h05, 16'hffff);
    rd_chk("diag low", 16'h40b4, 8'h05, 16'h0000);
    rd_chk("diag high", 16'h40b5, 8'h80, 16'h0000);
    rd_chk("diag length", 16'h40b5, 8'h00, 16'h0080);
    rd_chk("unmapped", 16'h5000, 8'h01, 16'h0000);
    $display("diagnostic test done");

    rd_chk("update length", 16'h40c4, 8'h00, 16'h0005);
    rd_chk("update min reset", 16'h40c4, 8'h01, 16'hffff);
    rd_chk("update max reset", 16'h40c4, 8'h02, 16'h0000);
    mn = 16'hffff;
    mx = 16'h0000;
    for (int m = 0; m < 3; m++) begin
      pulse(3'b010);
      repeat (dur[m]) @(posedge clk_i);
      pulse(3'b001);
      if (us_exp[m] < mn) mn = 16'(us_exp[m]);
      if (us_exp[m] > mx) mx = 16'(us_exp[m]);
      rd_chk("update current", 16'h40c4, 8'h03, 16'(us_exp[m]));
      rd_chk("update min", 16'h40c4, 8'h01, mn);
      rd_chk("update max", 16'h40c4, 8'h02, mx);
    end
    wb(1'b1, 16'h40c4, 8'h01, 16'h0007);
    rd_chk("update min write", 16'h40c4, 8'h01, 16'h0007);
    $display("update time test done");
    tally_and_finish();
  end
endmodule
